// ===== logic/dac_twi_pkg.sv
// Constants shared by the two-wire DAC slave interface
package dac_twi_pkg;
    // Address variants, upper six bits
    localparam logic [5:0] ADDR_UPPER_L = 6'h08;
    localparam logic [5:0] ADDR_UPPER_M = 6'h09;
    localparam logic [5:0] ADDR_UPPER_N = 6'h1A;
    localparam logic [5:0] ADDR_UPPER_P = 6'h2A;
    // Power-down encodings
    localparam logic [1:0] PD_UP = 2'h0;
    localparam logic [1:0] PD_FLOAT = 2'h1;
    localparam logic [1:0] PD_1K = 2'h2;
    localparam logic [1:0] PD_100K = 2'h3;
    localparam logic [1:0] PD_RESET = PD_100K;
    localparam logic [11:0] CODE_RESET = 12'h000;
    // Command nibbles
    localparam logic [3:0] CMD_LOAD_BOTH = 4'hC;
    localparam logic [3:0] CMD_LOAD_INPUT = 4'hD;
    localparam logic [3:0] CMD_LOAD_SHIFT = 4'hE;
    localparam logic [3:0] CMD_COPY = 4'hF;
    localparam logic [1:0] CMD_TOP_READ = 2'h2;
    localparam logic [1:0] CMD_TOP_PD = 2'h1;
    // Bit counter: bits 0..7 data, 8 acknowledge
    localparam logic [3:0] BIT_ACK = 4'h8;
    localparam logic [3:0] BIT_LAST = 4'h7;
    // Value after START; the clock fall that follows START wraps it to bit 0
    localparam logic [3:0] BIT_ARMED = 4'hF;
    // Timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int SCL_MAX_KHZ = 400;
    localparam int SCL_MIN_PERIOD_CYC = 1000000 / (SCL_MAX_KHZ * CLK_PERIOD_NS);

    typedef enum logic [2:0]
    {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_WRITE = 3'b010,
        ST_READ = 3'b011,
        ST_IGNORE = 3'b100
    } link_state_t;
endpackage

// ===== logic/twi_line_sync.sv
// Two-flop synchroniser and edge finder for the serial clock and data pins
`timescale 1ns/1ps
module twi_line_sync
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_sync_n,
    // Raw pins
    input wire logic scl_in,
    input wire logic sda_in,
    // Sampled levels and events
    output logic scl_level,
    output logic sda_level,
    output logic scl_rise,
    output logic scl_fall,
    output logic start_seen,
    output logic stop_seen
);
    logic [1:0] scl_meta_ff;
    logic [1:0] sda_meta_ff;
    logic scl_prev_ff;
    logic sda_prev_ff;

    // First stage read only by second stage
    always_ff @(posedge ref_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            scl_meta_ff <= 2'h3;
            sda_meta_ff <= 2'h3;
            scl_prev_ff <= 1'b1;
            sda_prev_ff <= 1'b1;
        end
        else
        begin
            scl_meta_ff <= {scl_meta_ff[0], scl_in};
            sda_meta_ff <= {sda_meta_ff[0], sda_in};
            scl_prev_ff <= scl_meta_ff[1];
            sda_prev_ff <= sda_meta_ff[1];
        end
    end

    assign scl_level = scl_meta_ff[1];
    assign sda_level = sda_meta_ff[1];
    assign scl_rise = scl_meta_ff[1] & ~scl_prev_ff;
    assign scl_fall = ~scl_meta_ff[1] & scl_prev_ff;
    // Data edges with clock high both now and before are conditions
    assign start_seen = scl_meta_ff[1] & scl_prev_ff & sda_prev_ff & ~sda_meta_ff[1];
    assign stop_seen = scl_meta_ff[1] & scl_prev_ff & ~sda_prev_ff & sda_meta_ff[1];
endmodule

// ===== logic/dac_twi_slave.sv
// Two-wire slave interface of a 12-bit DAC: framing, address, command decode
`timescale 1ns/1ps
module dac_twi_slave
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Bus pins
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // Strap and variant select
    input wire logic addr_select,
    input wire logic [1:0] variant_sel,
    // DAC state
    output logic [11:0] input_code,
    output logic [11:0] dac_code,
    output logic powerdown_select_high,
    output logic powerdown_select_low,
    output logic bus_busy
);
    logic [1:0] rst_pipe_ff;
    logic rst_sync_n;
    logic scl_level;
    logic sda_level;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    dac_twi_pkg::link_state_t state_ff;
    dac_twi_pkg::link_state_t nxt_state;
    logic [3:0] bit_cnt_ff;
    logic [7:0] shift_ff;
    logic first_byte_ff;
    logic [3:0] command_nibble_ff;
    logic [3:0] hi_code_ff;
    logic [11:0] input_code_ff;
    logic [11:0] dac_code_ff;
    logic [1:0] pd_ff;
    logic sda_low_ff;
    logic master_nack_ff;
    logic [1:0] addr_sel_meta_ff;
    logic [6:0] own_addr;
    logic [7:0] next_byte;
    logic addr_bit_ok;
    logic in_frame;

    ////////////////////////////////////////////////////////////////////////////
    // Reset release and pin conditioning

    // Reset asserts at once, releases through two flops
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            rst_pipe_ff <= 2'h0;
        else
            rst_pipe_ff <= {rst_pipe_ff[0], 1'b1};
    end
    assign rst_sync_n = rst_pipe_ff[1];

    twi_line_sync u_sync
    (
        .ref_clk(ref_clk),
        .rst_sync_n(rst_sync_n),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .scl_level(scl_level),
        .sda_level(sda_level),
        .scl_rise(scl_rise),
        .scl_fall(scl_fall),
        .start_seen(start_seen),
        .stop_seen(stop_seen)
    );

    // Address-select pin is a static strap but still synchronised
    always_ff @(posedge ref_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            addr_sel_meta_ff <= 2'h0;
        else
            addr_sel_meta_ff <= {addr_sel_meta_ff[0], addr_select};
    end

    ////////////////////////////////////////////////////////////////////////////
    // Address helpers

    // Preset upper bits per variant, lowest bit from strap
    function automatic logic [6:0] slave_address(input logic [1:0] sel, input logic lsb);
        logic [5:0] upper;
        upper = dac_twi_pkg::ADDR_UPPER_L;
        case (sel)
            2'h0: upper = dac_twi_pkg::ADDR_UPPER_L;
            2'h1: upper = dac_twi_pkg::ADDR_UPPER_M;
            2'h2: upper = dac_twi_pkg::ADDR_UPPER_N;
            default: upper = dac_twi_pkg::ADDR_UPPER_P;
        endcase
        return {upper, lsb};
    endfunction

    assign own_addr = slave_address(variant_sel, addr_sel_meta_ff[1]);
    assign next_byte = {shift_ff[6:0], sda_level};
    // Bit under compare is bit 6 - count of the address
    assign addr_bit_ok = (bit_cnt_ff > 4'h6) ||
        (sda_level == own_addr[3'(4'h6 - bit_cnt_ff)]);
    assign in_frame = (state_ff != dac_twi_pkg::ST_IDLE) &&
        (state_ff != dac_twi_pkg::ST_IGNORE);

    ////////////////////////////////////////////////////////////////////////////
    // Transfer state

    // STOP beats everything; START restarts address phase from any state
    always_comb
    begin
        nxt_state = state_ff;
        if (stop_seen)
            nxt_state = dac_twi_pkg::ST_IDLE;
        else if (start_seen)
            nxt_state = dac_twi_pkg::ST_ADDR;
        else
        begin
            case (state_ff)
                dac_twi_pkg::ST_IDLE:
                    nxt_state = dac_twi_pkg::ST_IDLE;
                dac_twi_pkg::ST_ADDR:
                begin
                    if (scl_rise && !addr_bit_ok)
                        nxt_state = dac_twi_pkg::ST_IGNORE;
                    else if (scl_fall && bit_cnt_ff == dac_twi_pkg::BIT_ACK)
                        nxt_state = shift_ff[0] ? dac_twi_pkg::ST_READ
                                                : dac_twi_pkg::ST_WRITE;
                end
                dac_twi_pkg::ST_READ:
                begin
                    // Master nack ends our transmission
                    if (scl_fall && bit_cnt_ff == dac_twi_pkg::BIT_ACK && master_nack_ff)
                        nxt_state = dac_twi_pkg::ST_IGNORE;
                end
                dac_twi_pkg::ST_WRITE:
                    nxt_state = dac_twi_pkg::ST_WRITE;
                dac_twi_pkg::ST_IGNORE:
                    nxt_state = dac_twi_pkg::ST_IGNORE;
                default:
                    nxt_state = dac_twi_pkg::ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            state_ff <= dac_twi_pkg::ST_IDLE;
        else
            state_ff <= nxt_state;
    end

    // Bit counter: 0..7 data bits, 8 is the acknowledge clock
    // Armed one below zero at START, as the fall after START carries no bit
    always_ff @(posedge ref_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            bit_cnt_ff <= 4'h0;
        else if (start_seen)
            bit_cnt_ff <= dac_twi_pkg::BIT_ARMED;
        else if (!in_frame)
            bit_cnt_ff <= 4'h0;
        else if (scl_fall)
            bit_cnt_ff <= (bit_cnt_ff == dac_twi_pkg::BIT_ACK) ? 4'h0
                                                                 : bit_cnt_ff + 4'h1;
    end

    // Sample data on rising clock; clock ignored outside a frame
    always_ff @(posedge ref_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            shift_ff <= 8'h00;
        else if (in_frame && scl_rise && bit_cnt_ff <= dac_twi_pkg::BIT_LAST)
            shift_ff <= next_byte;
    end

    // Master acknowledge sampled on ninth rising clock while we transmit
    always_ff @(posedge ref_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            master_nack_ff <= 1'b0;
        else if (state_ff == dac_twi_pkg::ST_READ && scl_rise &&
                 bit_cnt_ff == dac_twi_pkg::BIT_ACK)
            master_nack_ff <= sda_level;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Write decode

    // Byte parity in a write or read; any START or STOP drops a half word
    always_ff @(posedge ref_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            first_byte_ff <= 1'b1;
        else if ((state_ff != dac_twi_pkg::ST_WRITE && state_ff != dac_twi_pkg::ST_READ) ||
                 start_seen || stop_seen)
            first_byte_ff <= 1'b1;
        else if (scl_fall && bit_cnt_ff == dac_twi_pkg::BIT_ACK)
            first_byte_ff <= ~first_byte_ff;
    end

    // First byte: command nibble and code bits 11..8, held until word completes
    always_ff @(posedge ref_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            command_nibble_ff <= 4'h0;
            hi_code_ff <= 4'h0;
        end
        else if (state_ff == dac_twi_pkg::ST_WRITE && first_byte_ff && scl_fall &&
                 bit_cnt_ff == dac_twi_pkg::BIT_ACK)
        begin
            command_nibble_ff <= shift_ff[7:4];
            hi_code_ff <= shift_ff[3:0];
        end
    end

    // Registers change only at the fall ending the second byte's acknowledge
    always_ff @(posedge ref_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            input_code_ff <= dac_twi_pkg::CODE_RESET;
            dac_code_ff <= dac_twi_pkg::CODE_RESET;
            pd_ff <= dac_twi_pkg::PD_RESET;
        end
        else if (state_ff == dac_twi_pkg::ST_WRITE && !first_byte_ff && scl_fall &&
                 bit_cnt_ff == dac_twi_pkg::BIT_ACK)
        begin
            case (command_nibble_ff)
                dac_twi_pkg::CMD_LOAD_BOTH:
                begin
                    input_code_ff <= {hi_code_ff, shift_ff};
                    dac_code_ff <= {hi_code_ff, shift_ff};
                end
                dac_twi_pkg::CMD_LOAD_INPUT:
                    input_code_ff <= {hi_code_ff, shift_ff};
                dac_twi_pkg::CMD_LOAD_SHIFT:
                begin
                    input_code_ff <= {hi_code_ff, shift_ff};
                    dac_code_ff <= input_code_ff;
                end
                dac_twi_pkg::CMD_COPY:
                    dac_code_ff <= input_code_ff;
                default:
                begin
                    // Power-down select from code bits 11 and 10; rest ignored
                    if (command_nibble_ff[3:2] == dac_twi_pkg::CMD_TOP_PD)
                        pd_ff <= hi_code_ff[3:2];
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Data line drive

    // Changes only on falling clock so data is stable while clock is high
    always_ff @(posedge ref_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            sda_low_ff <= 1'b0;
        else if (start_seen || stop_seen || !in_frame)
            sda_low_ff <= 1'b0;
        else if (scl_fall)
        begin
            if (bit_cnt_ff == dac_twi_pkg::BIT_LAST &&
                state_ff != dac_twi_pkg::ST_READ)
                sda_low_ff <= 1'b1;
            else if (state_ff == dac_twi_pkg::ST_ADDR &&
                     bit_cnt_ff == dac_twi_pkg::BIT_ACK && shift_ff[0])
                sda_low_ff <= ~read_bit(1'b1, 3'h0);
            else if (state_ff == dac_twi_pkg::ST_READ && bit_cnt_ff < dac_twi_pkg::BIT_LAST)
                sda_low_ff <= ~read_bit(first_byte_ff, 3'(bit_cnt_ff + 4'h1));
            else if (state_ff == dac_twi_pkg::ST_READ &&
                     bit_cnt_ff == dac_twi_pkg::BIT_ACK && !master_nack_ff)
                sda_low_ff <= ~read_bit(~first_byte_ff, 3'h0);
            else
                sda_low_ff <= 1'b0;
        end
    end

    // Read word: byte one is 0000 and code 11..8, byte two code 7..0
    function automatic logic read_bit(input logic first, input logic [2:0] idx);
        logic [15:0] word;
        word = {4'h0, dac_code_ff};
        return first ? word[4'hF - {1'b0, idx}] : word[4'h7 - {1'b0, idx}];
    endfunction

    assign sda_out = 1'b0;
    assign sda_oe = sda_low_ff;
    assign input_code = input_code_ff;
    assign dac_code = dac_code_ff;
    assign powerdown_select_high = pd_ff[1];
    assign powerdown_select_low = pd_ff[0];
    assign bus_busy = in_frame;

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    a_stop_goes_idle: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
        stop_seen |=> state_ff == dac_twi_pkg::ST_IDLE)
        else $error("stop did not release");
    a_start_to_addr: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
        start_seen && !stop_seen |=> state_ff == dac_twi_pkg::ST_ADDR &&
        bit_cnt_ff == dac_twi_pkg::BIT_ARMED)
        else $error("start did not open address phase");
    a_ignore_quiet: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
        state_ff == dac_twi_pkg::ST_IGNORE |-> !sda_oe)
        else $error("driving while ignoring");
    a_idle_quiet: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
        state_ff == dac_twi_pkg::ST_IDLE && !start_seen |=> state_ff == dac_twi_pkg::ST_IDLE)
        else $error("left idle without start");
    a_addr_mismatch: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
        state_ff == dac_twi_pkg::ST_ADDR && scl_rise && !addr_bit_ok && !start_seen
        && !stop_seen |=> state_ff == dac_twi_pkg::ST_IGNORE)
        else $error("mismatch not dropped");
    a_ack_held: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
        state_ff == dac_twi_pkg::ST_WRITE && scl_fall && bit_cnt_ff == dac_twi_pkg::BIT_LAST
        && !start_seen && !stop_seen |=> sda_oe)
        else $error("no acknowledge");
    a_regs_stable: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
        !(scl_fall && bit_cnt_ff == dac_twi_pkg::BIT_ACK) |=> $stable(dac_code_ff)
        && $stable(input_code_ff) && $stable(pd_ff))
        else $error("register moved off acknowledge edge");
    a_pd_write: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
        state_ff == dac_twi_pkg::ST_WRITE && !first_byte_ff && scl_fall &&
        bit_cnt_ff == dac_twi_pkg::BIT_ACK &&
        command_nibble_ff[3:2] == dac_twi_pkg::CMD_TOP_PD
        |=> pd_ff == $past(hi_code_ff[3:2]))
        else $error("power-down bits not loaded");
    a_sda_stable_high: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
        scl_level && $past(scl_level) && in_frame |-> $stable(sda_oe))
        else $error("data driven change while clock high");
    // Read word always opens with a zero, so the line stays low past the ack
    a_read_lead_bit: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
        state_ff == dac_twi_pkg::ST_ADDR && scl_fall && bit_cnt_ff == dac_twi_pkg::BIT_ACK &&
        shift_ff[0] && !start_seen && !stop_seen |=> sda_oe)
        else $error("first read bit not driven");
    a_nack_release: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
        state_ff == dac_twi_pkg::ST_READ && scl_fall && bit_cnt_ff == dac_twi_pkg::BIT_ACK &&
        master_nack_ff |=> !sda_oe && state_ff == dac_twi_pkg::ST_IGNORE)
        else $error("still driving after master nack");
    c_write_word: cover property (@(posedge ref_clk) disable iff (!rst_sync_n)
        state_ff == dac_twi_pkg::ST_WRITE && $changed(dac_code_ff));
    c_read_entered: cover property (@(posedge ref_clk) disable iff (!rst_sync_n)
        state_ff == dac_twi_pkg::ST_READ);
    c_mismatch: cover property (@(posedge ref_clk) disable iff (!rst_sync_n)
        state_ff == dac_twi_pkg::ST_IGNORE);
    c_powerup: cover property (@(posedge ref_clk) disable iff (!rst_sync_n)
        pd_ff == dac_twi_pkg::PD_UP);
endmodule

// ===== verif/twi_bus_master.sv
// Behavioural two-wire bus master with open-drain clock and data pulls
`timescale 1ns/1ps
module twi_bus_master
(
    // Pull-downs onto the wired lines
    output logic scl_pull,
    output logic sda_pull,
    // Resolved data line
    input wire logic sda_line
);
    // Half of the 125 ns link period
    localparam realtime HALF = 62.5;

    // Both lines released, so the pull-ups show idle
    initial
    begin
        scl_pull = 1'b0;
        sda_pull = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Start or repeated start; first wait lets a slave drop its ack first
    task automatic start_cond();
        #HALF sda_pull = 1'b0;
        #HALF scl_pull = 1'b0;
        #HALF sda_pull = 1'b1;
        #HALF scl_pull = 1'b1;
    endtask

    // Stop: data rises while the clock is high, clock then stands still
    task automatic stop_cond();
        #20 sda_pull = 1'b1;
        #42.5 scl_pull = 1'b0;
        #HALF sda_pull = 1'b0;
        #HALF;
    endtask

    // One clock pulse; data moves only while the clock is low
    task automatic clock_bit(input logic b, output logic s);
        #20 sda_pull = ~b;
        #42.5 scl_pull = 1'b0;
        #31 s = sda_line;
        #31.5 scl_pull = 1'b1;
    endtask

    // Eight bits MSB first, then the line level in the ack slot
    task automatic put_byte(input logic [7:0] v, output logic a);
        logic s;
        for (int i = 7; i >= 0; i--)
            clock_bit(v[i], s);
        clock_bit(1'b1, a);
    endtask

    // Eight bits read, then our ack (low) or nack (high)
    task automatic get_byte(input logic nack, output logic [7:0] v);
        logic s;
        for (int i = 7; i >= 0; i--)
            clock_bit(1'b1, v[i]);
        clock_bit(nack, s);
    endtask
endmodule

// ===== verif/test_dac_twi_slave.sv
// Self-checking bench for the two-wire DAC slave interface
`timescale 1ns/1ps
module test_dac_twi_slave;
    logic ref_clk;
    logic rst_n;
    logic addr_select;
    logic [1:0] variant_sel;
    logic scl_pull;
    logic sda_pull;
    logic sda_out;
    logic sda_oe;
    logic [11:0] input_code;
    logic [11:0] dac_code;
    logic powerdown_select_high;
    logic powerdown_select_low;
    logic bus_busy;
    logic [6:0] dev_addr;
    logic ack;
    logic [7:0] rd;
    logic [5:0] uppers [4];
    int mismatches = 0;
    int check_count = 0;
    int cycles = 0;
    wire scl_line;
    wire sda_line;

    // Pull-ups: a line is low only while some party pulls it
    assign scl_line = ~scl_pull;
    assign sda_line = ~(sda_pull | (sda_oe & ~sda_out));

    dac_twi_slave u_dac_twi_slave
    (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .scl_in(scl_line),
        .sda_in(sda_line),
        .sda_out(sda_out),
        .sda_oe(sda_oe),
        .addr_select(addr_select),
        .variant_sel(variant_sel),
        .input_code(input_code),
        .dac_code(dac_code),
        .powerdown_select_high(powerdown_select_high),
        .powerdown_select_low(powerdown_select_low),
        .bus_busy(bus_busy)
    );

    twi_bus_master u_twi_bus_master
    (
        .scl_pull(scl_pull),
        .sda_pull(sda_pull),
        .sda_line(sda_line)
    );

    ////////////////////////////////////////////////////////////////////////
    // Clock and hang guard; ceiling well above the expected 7.8k cycles
    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 60000)
        begin
            mismatches++;
            wrap_up();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Shared checking and transfer tasks
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic check_regs(input logic [11:0] inp, input logic [11:0] dac,
        input logic [1:0] pd);
        check("input_code", input_code, inp);
        check("dac_code", dac_code, dac);
        check("powerdown", {10'h0, powerdown_select_high, powerdown_select_low}, {10'h0, pd});
    endtask

    // Strap change only under reset, since the pins are static
    task automatic do_reset(input logic [1:0] v);
        @(posedge ref_clk);
        rst_n <= 1'b0;
        variant_sel <= v;
        addr_select <= v[0];
        repeat (20) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (6) @(posedge ref_clk);
    endtask

    // A missing ack fails the run rather than being retried
    task automatic send_word(input logic [3:0] cmd, input logic [11:0] code);
        u_twi_bus_master.put_byte({cmd, code[11:8]}, ack);
        check("ack byte1", {11'h0, ack}, 12'h000);
        u_twi_bus_master.put_byte(code[7:0], ack);
        check("ack byte2", {11'h0, ack}, 12'h000);
    endtask

    task automatic open_frame(input logic rw);
        u_twi_bus_master.start_cond();
        u_twi_bus_master.put_byte({dev_addr, rw}, ack);
        check("ack address", {11'h0, ack}, 12'h000);
    endtask

    task automatic write_frame(input logic [3:0] cmd, input logic [11:0] code);
        open_frame(1'b0);
        send_word(cmd, code);
        u_twi_bus_master.stop_cond();
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        rst_n = 1'b0;
        addr_select = 1'b0;
        variant_sel = 2'h0;
        uppers = '{dac_twi_pkg::ADDR_UPPER_L, dac_twi_pkg::ADDR_UPPER_M,
            dac_twi_pkg::ADDR_UPPER_N, dac_twi_pkg::ADDR_UPPER_P};
        // Every variant: reset state, foreign address ignored, own address loads
        for (int v = 0; v < 4; v++)
        begin
            do_reset(v[1:0]);
            dev_addr = {uppers[v], v[0]};
            check_regs(12'h000, 12'h000, 2'b11);
            check("busy idle", {11'h0, bus_busy}, 12'h000);
            u_twi_bus_master.start_cond();
            u_twi_bus_master.put_byte({dev_addr ^ (v[0] ? 7'h01 : 7'h40), 1'b0}, ack);
            check("nack address", {11'h0, ack}, 12'h001);
            check("busy dropped", {11'h0, bus_busy}, 12'h000);
            u_twi_bus_master.put_byte({dac_twi_pkg::CMD_LOAD_BOTH, 4'h7}, ack);
            check("ignored byte", {11'h0, ack}, 12'h001);
            u_twi_bus_master.stop_cond();
            check_regs(12'h000, 12'h000, 2'b11);
            write_frame(dac_twi_pkg::CMD_LOAD_BOTH, 12'hA51 + 12'(v));
            check_regs(12'hA51 + 12'(v), 12'hA51 + 12'(v), 2'b11);
        end
        // Remaining load commands, then two ignored commands: 8 (a read request) and 3
        write_frame(dac_twi_pkg::CMD_LOAD_INPUT, 12'h5A5);
        check_regs(12'h5A5, 12'hA54, 2'b11);
        write_frame(dac_twi_pkg::CMD_LOAD_SHIFT, 12'h3C3);
        check_regs(12'h3C3, 12'h5A5, 2'b11);
        write_frame(dac_twi_pkg::CMD_COPY, 12'hFFF);
        check_regs(12'h3C3, 12'h3C3, 2'b11);
        write_frame(4'h8, 12'h123);
        check_regs(12'h3C3, 12'h3C3, 2'b11);
        write_frame(4'h3, 12'h456);
        check_regs(12'h3C3, 12'h3C3, 2'b11);
        // Every power-down setting, low command bits varied, ending powered up
        for (int p = 3; p >= 0; p--)
        begin
            write_frame({2'b01, p[1:0]}, {p[1:0], 10'h3FF});
            check_regs(12'h3C3, 12'h3C3, p[1:0]);
        end
        // Two words in one frame, then repeated start into a read
        open_frame(1'b0);
        send_word(dac_twi_pkg::CMD_LOAD_INPUT, 12'h111);
        send_word(dac_twi_pkg::CMD_LOAD_BOTH, 12'h8E7);
        repeat (5) @(posedge ref_clk);
        check_regs(12'h8E7, 12'h8E7, 2'b00);
        check("busy frame", {11'h0, bus_busy}, 12'h001);
        open_frame(1'b1);
        u_twi_bus_master.get_byte(1'b0, rd);
        check("read byte1", {4'h0, rd}, 12'h008);
        u_twi_bus_master.get_byte(1'b1, rd);
        check("read byte2", {4'h0, rd}, 12'h0E7);
        u_twi_bus_master.stop_cond();
        check("busy after stop", {11'h0, bus_busy}, 12'h000);
        // Write cut short by a stop in mid-byte, then a clean write
        open_frame(1'b0);
        u_twi_bus_master.put_byte({dac_twi_pkg::CMD_LOAD_BOTH, 4'h1}, ack);
        repeat (3) u_twi_bus_master.clock_bit(1'b0, ack);
        u_twi_bus_master.stop_cond();
        check_regs(12'h8E7, 12'h8E7, 2'b00);
        write_frame(dac_twi_pkg::CMD_LOAD_BOTH, 12'h0F0);
        check_regs(12'h0F0, 12'h0F0, 2'b00);
        wrap_up();
    end
endmodule
